// ===== spg_pin_set.sv
// pin output set register block with apb slave and per-pin gpio latches
//
// Overview of operation
// - bits 31 to 12 read zero and writes to them are ignored.
// - writing 1 to bit 11 sets the data-in pin latch; 0 leaves it.
// - writing 1 to bit 10 sets the data-out pin latch; 0 leaves it.
// - writing 1 to bit 9 sets the serial clock pin latch; 0 leaves it.
// - writing 1 to bit 8 sets the enable pin latch; 0 leaves it.
// - writing 1 to bit n of 7..0 sets chip select n latch; 0 leaves it.
// - reads of bits 11..0 return live pin levels, not written values; bits of absent chip selects read zero.
// - a set acts only while its pin is a gpio output.
// - each latch gives the level driven while its pin is a gpio output.
`timescale 1ns/10ps
module spg_pin_set #(
	parameter int CS_COUNT = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// apb slave
	input wire spg_pkg::spg_apb_req_t i_apb,
	output logic [spg_pkg::SPG_DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// clear strobes from the companion clear register, one per pin
	input wire logic [spg_pkg::SPG_PIN_N-1:0] i_latch_clear,
	// serial transfer logic pin drive when pins are not gpio
	input wire logic [spg_pkg::SPG_PIN_N-1:0] i_func_out,
	input wire logic [spg_pkg::SPG_PIN_N-1:0] i_func_oe,
	// pins
	input wire logic [spg_pkg::SPG_PIN_N-1:0] i_pin_in,
	output logic [spg_pkg::SPG_PIN_N-1:0] o_pin_out,
	output logic [spg_pkg::SPG_PIN_N-1:0] o_pin_oe,
	// latch state for the serial logic and the data register owner
	output logic [spg_pkg::SPG_PIN_N-1:0] o_pin_output_data
);
	import spg_pkg::*;

	// mask of implemented bits: the four named pins plus present chip selects
	function automatic logic [SPG_PIN_N-1:0] pin_mask();
		logic [SPG_PIN_N-1:0] m;
		m = '0;
		m[SPG_BIT_DATA_IN] = 1'b1;
		m[SPG_BIT_DATA_OUT] = 1'b1;
		m[SPG_BIT_SERIAL_CLOCK] = 1'b1;
		m[SPG_BIT_ENABLE] = 1'b1;
		for (int k = 0; k < SPG_CS_MAX; k++) begin
			if (k < CS_COUNT) begin
				m[SPG_BIT_CS_LSB + k] = 1'b1;
			end
		end
		return m;
	endfunction

	// true when the address selects a mapped register
	function automatic logic addr_hit(input logic [SPG_ADDR_W-1:0] a);
		return (a == SPG_OFF_PIN_FUNCTION) || (a == SPG_OFF_PIN_DIRECTION) ||
			(a == SPG_OFF_PIN_OUTPUT_DATA) || (a == SPG_OFF_PIN_OUTPUT_SET);
	endfunction

	localparam logic [SPG_PIN_N-1:0] MASK = pin_mask();

	logic [SPG_PIN_N-1:0] pin_function;
	logic [SPG_PIN_N-1:0] pin_direction;
	logic [SPG_PIN_N-1:0] latch;
	logic [SPG_PIN_N-1:0] wdata_pins;
	logic setup_phase;
	logic access_wr;
	logic wr_function;
	logic wr_direction;
	logic wr_data;
	logic wr_set;
	logic [SPG_DATA_W-1:0] next_prdata;

	// bus phase decode; the slave never inserts wait states
	assign setup_phase = i_apb.psel & ~i_apb.penable;
	assign access_wr = i_apb.psel & i_apb.penable & i_apb.pwrite & o_pready;
	assign o_pready = 1'b1;

	// only implemented pin bits of the write data go anywhere
	assign wdata_pins = i_apb.pwdata[SPG_PIN_N-1:0] & MASK;

	// per register write strobes at the access edge
	assign wr_function = access_wr && (i_apb.paddr == SPG_OFF_PIN_FUNCTION);
	assign wr_direction = access_wr && (i_apb.paddr == SPG_OFF_PIN_DIRECTION);
	assign wr_data = access_wr && (i_apb.paddr == SPG_OFF_PIN_OUTPUT_DATA);
	assign wr_set = access_wr && (i_apb.paddr == SPG_OFF_PIN_OUTPUT_SET);

	// function select: 1 makes the pin general purpose
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			pin_function <= SPG_RST_PIN_FUNCTION;
		end else if (wr_function) begin
			pin_function <= wdata_pins;
		end
	end

	// direction: 1 makes a general purpose pin an output
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			pin_direction <= SPG_RST_PIN_DIRECTION;
		end else if (wr_direction) begin
			pin_direction <= wdata_pins;
		end
	end

	// one cell per pin; every set bit of one write lands in the same edge
	generate
		for (genvar g = 0; g < SPG_PIN_N; g++) begin : g_pin
			spg_pin_ctrl_t ctrl;
			spg_pin_cmd_t cmd;
			assign ctrl.gpio = pin_function[g] & MASK[g];
			assign ctrl.output_dir = pin_direction[g];
			assign cmd.set = wr_set & wdata_pins[g];
			assign cmd.clr = i_latch_clear[g] & MASK[g];
			assign cmd.load = wr_data & MASK[g];
			assign cmd.load_val = wdata_pins[g];
			spg_pin_cell u_cell (
				.i_sys_clk(i_sys_clk),
				.i_reset(i_reset),
				.i_ctrl(ctrl),
				.i_cmd(cmd),
				.i_func_out(i_func_out[g]),
				.i_func_oe(i_func_oe[g]),
				.o_latch(latch[g]),
				.o_pin_out(o_pin_out[g]),
				.o_pin_oe(o_pin_oe[g])
			);
		end
	endgenerate

	assign o_pin_output_data = latch;

	// read mux; the set register shows the live pin levels
	always_comb begin
		next_prdata = SPG_RST_RDATA;
		unique case (i_apb.paddr)
			SPG_OFF_PIN_FUNCTION: next_prdata[SPG_PIN_N-1:0] = pin_function;
			SPG_OFF_PIN_DIRECTION: next_prdata[SPG_PIN_N-1:0] = pin_direction;
			SPG_OFF_PIN_OUTPUT_DATA: next_prdata[SPG_PIN_N-1:0] = latch & MASK;
			SPG_OFF_PIN_OUTPUT_SET: next_prdata[SPG_PIN_N-1:0] = i_pin_in & MASK;
			default: next_prdata = SPG_RST_RDATA;
		endcase
	end

	// read data captured in the setup phase, held through the access phase
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_prdata <= SPG_RST_RDATA;
		end else if (setup_phase) begin
			o_prdata <= i_apb.pwrite ? SPG_RST_RDATA : next_prdata;
		end
	end

	// unmapped address answers with an error in the access phase
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_pslverr <= 1'b0;
		end else if (setup_phase) begin
			o_pslverr <= ~addr_hit(i_apb.paddr);
		end else if (!i_apb.psel) begin
			o_pslverr <= 1'b0;
		end
	end

endmodule

// ===== spg_pkg.sv
// package with register map, field layout and carrier types of the pin set block
package spg_pkg;

	// bus geometry
	localparam int SPG_ADDR_W = 12;
	localparam int SPG_DATA_W = 32;
	localparam int SPG_PIN_N = 12;
	localparam int SPG_CS_MAX = 8;

	// register byte offsets
	localparam logic [SPG_ADDR_W-1:0] SPG_OFF_PIN_FUNCTION = 12'h000;
	localparam logic [SPG_ADDR_W-1:0] SPG_OFF_PIN_DIRECTION = 12'h004;
	localparam logic [SPG_ADDR_W-1:0] SPG_OFF_PIN_OUTPUT_DATA = 12'h008;
	localparam logic [SPG_ADDR_W-1:0] SPG_OFF_PIN_OUTPUT_SET = 12'h00C;

	// field positions inside every pin register
	localparam int SPG_BIT_DATA_IN = 11;
	localparam int SPG_BIT_DATA_OUT = 10;
	localparam int SPG_BIT_SERIAL_CLOCK = 9;
	localparam int SPG_BIT_ENABLE = 8;
	localparam int SPG_BIT_CS_LSB = 0;

	// reset values
	localparam logic [SPG_PIN_N-1:0] SPG_RST_PIN_FUNCTION = 12'h000;
	localparam logic [SPG_PIN_N-1:0] SPG_RST_PIN_DIRECTION = 12'h000;
	localparam logic SPG_RST_LATCH = 1'b0;
	localparam logic [SPG_DATA_W-1:0] SPG_RST_RDATA = 32'h00000000;

	// apb request carrier
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [SPG_ADDR_W-1:0] paddr;
		logic [SPG_DATA_W-1:0] pwdata;
	} spg_apb_req_t;

	// per pin configuration carrier
	typedef struct packed {
		logic gpio;
		logic output_dir;
	} spg_pin_ctrl_t;

	// per pin latch command carrier
	typedef struct packed {
		logic set;
		logic clr;
		logic load;
		logic load_val;
	} spg_pin_cmd_t;

endpackage

// ===== spg_pin_cell.sv
// one pin: output-data latch with gated set and clear, ungated direct load, plus pin output mux
`timescale 1ns/10ps
module spg_pin_cell (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire spg_pkg::spg_pin_ctrl_t i_ctrl,
	input wire spg_pkg::spg_pin_cmd_t i_cmd,
	input wire logic i_func_out,
	input wire logic i_func_oe,
	output logic o_latch,
	output logic o_pin_out,
	output logic o_pin_oe
);
	import spg_pkg::*;

	logic gpio_out;

	// the set and clear strobes only reach the latch in gpio output mode
	assign gpio_out = i_ctrl.gpio & i_ctrl.output_dir;

	// output-data latch: set beats clear beats direct load
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_latch <= SPG_RST_LATCH;
		end else if (i_cmd.set && gpio_out) begin
			o_latch <= 1'b1;
		end else if (i_cmd.clr && gpio_out) begin
			o_latch <= 1'b0;
		end else if (i_cmd.load) begin
			o_latch <= i_cmd.load_val;
		end
	end

	// gpio output drives the latch, gpio input floats, else serial logic owns the pin
	always_comb begin
		if (i_ctrl.gpio) begin
			o_pin_out = o_latch;
			o_pin_oe = i_ctrl.output_dir;
		end else begin
			o_pin_out = i_func_out;
			o_pin_oe = i_func_oe;
		end
	end

endmodule

// ===== spg_pin_set_monitor.sv
// assertion checker for the pin set block ports
`timescale 1ns/10ps
module spg_pin_set_monitor import spg_pkg::*; #(
	parameter int CS_COUNT = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire spg_pkg::spg_apb_req_t i_apb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	input wire logic [11:0] i_latch_clear,
	input wire logic [11:0] i_func_oe,
	input wire logic [11:0] i_pin_in,
	input wire logic [11:0] o_pin_out,
	input wire logic [11:0] o_pin_oe,
	input wire logic [11:0] o_pin_output_data
);
	localparam logic [11:0] VM = 12'hF00 | ((12'h001 << CS_COUNT) - 12'h001);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// access phase and set register decode
	wire acc = i_apb.psel & i_apb.penable;
	wire hit = i_apb.paddr == SPG_OFF_PIN_OUTPUT_SET;
	sequence set_wr;
		acc && i_apb.pwrite && hit;
	endsequence
	sequence rd_setup;
		i_apb.psel && !i_apb.penable && !i_apb.pwrite && hit;
	endsequence
	rsvd_zero_a: assert property (acc |-> o_prdata[31:12] == 20'h00000)
		else $error("upper read bits not zero");
	set_ones_a: assert property (set_wr |=> (o_pin_output_data & ~$past(o_pin_output_data)
		& ~$past(i_apb.pwdata[11:0])) == 12'h000) else $error("latch rose without a one");
	set_keeps_a: assert property (set_wr |=> ($past(o_pin_output_data) &
		$past(i_apb.pwdata[11:0]) & ~o_pin_output_data) == 12'h000) else $error("set latch fell");
	idle_hold_a: assert property (!(acc && i_apb.pwrite) && i_latch_clear == 12'h000
		|=> $stable(o_pin_output_data)) else $error("latch moved without a write");
	set_takes_a: assert property (set_wr |=> ($past(i_apb.pwdata[11:0]) & $past(o_pin_oe)
		& ~$past(i_func_oe) & ~o_pin_output_data) == 12'h000) else $error("set did not raise latch");
	gpio_drive_a: assert property (((o_pin_oe & ~i_func_oe) & (o_pin_out ^ o_pin_output_data))
		== 12'h000) else $error("gpio pin level differs from latch");
	live_read_a: assert property (rd_setup |=> o_prdata[11:0] == ($past(i_pin_in) & VM))
		else $error("read does not show pin levels");
	nongpio_set_a: assert property (set_wr |=> (o_pin_output_data & ~$past(o_pin_output_data)
		& ~$past(o_pin_oe)) == 12'h000) else $error("set acted on a non output pin");
	unmapped_a: assert property (i_apb.psel && !i_apb.penable && i_apb.paddr > 12'h00C
		|=> o_pslverr && o_prdata == 32'h00000000) else $error("unmapped access not flagged");
endmodule
bind spg_pin_set spg_pin_set_monitor #(.CS_COUNT(CS_COUNT)) u_mon (
	.i_sys_clk(i_sys_clk),
	.i_reset(i_reset),
	.i_apb(i_apb),
	.o_prdata(o_prdata),
	.o_pslverr(o_pslverr),
	.i_latch_clear(i_latch_clear),
	.i_func_oe(i_func_oe),
	.i_pin_in(i_pin_in),
	.o_pin_out(o_pin_out),
	.o_pin_oe(o_pin_oe),
	.o_pin_output_data(o_pin_output_data)
);

// ===== spg_pin_set_tb.sv
// self-checking bench for the pin set block with a reference model
`timescale 1ns/10ps
module spg_pin_set_tb;
	import spg_pkg::*;
	localparam logic [11:0] VM = 12'hF3F; // six chip selects present
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	spg_apb_req_t i_apb = '0;
	logic [31:0] o_prdata;
	logic o_pready, o_pslverr, e;
	logic [11:0] i_latch_clear = '0, i_func_out = '0, i_func_oe = '0, i_pin_in = '0;
	logic [11:0] o_pin_out, o_pin_oe, o_pin_output_data;
	logic [15:0] sd = 16'hF6E8;
	logic [31:0] d, r;
	int m_lat, m_fn, m_dir, n_fail, total_checks;
	always #12.5 i_sys_clk = ~i_sys_clk;
	spg_pin_set #(.CS_COUNT(6)) dut (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_apb(i_apb),
		.o_prdata(o_prdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr),
		.i_latch_clear(i_latch_clear),
		.i_func_out(i_func_out),
		.i_func_oe(i_func_oe),
		.i_pin_in(i_pin_in),
		.o_pin_out(o_pin_out),
		.o_pin_oe(o_pin_oe),
		.o_pin_output_data(o_pin_output_data)
	);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// one apb transfer, pins and serial drive refreshed at setup
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge i_sys_clk);
		sd = lfsr(sd);
		i_apb <= '{1'b1, 1'b0, w, a, wd};
		i_pin_in <= sd[11:0];
		i_func_out <= sd[15:4];
		i_func_oe <= sd[13:2];
		@(posedge i_sys_clk);
		i_apb.penable <= 1'b1;
		do @(posedge i_sys_clk); while (o_pready !== 1'b1);
		r = o_prdata;
		e = o_pslverr;
		i_apb <= '0;
		#1;
	endtask
	task mchk();
		chk(o_pin_output_data, m_lat);
		chk(o_pin_out, (m_fn & m_lat) | (~m_fn & i_func_out));
		chk(o_pin_oe, (m_fn & m_dir) | (~m_fn & i_func_oe));
	endtask
	task report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		n_fail++;
		report_and_stop();
	end
	// random mix of set, data, read, config and clear operations
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		#1;
		mchk();
		apb(1'b1, SPG_OFF_PIN_FUNCTION, VM);
		m_fn = VM;
		for (int i = 0; i < 300; i++) begin
			d = {sd, sd[15:12], sd[11:0] & VM};
			case (sd[1:0])
				2'd0: begin
					apb(1'b1, SPG_OFF_PIN_OUTPUT_SET, d);
					m_lat |= d[11:0] & m_fn & m_dir;
				end
				2'd1: begin
					apb(1'b1, SPG_OFF_PIN_OUTPUT_DATA, d);
					m_lat = d[11:0];
				end
				2'd2: begin
					apb(1'b0, SPG_OFF_PIN_OUTPUT_SET, d);
					chk(r, sd[11:0] & VM);
					chk(e, 0);
					apb(1'b0, 12'h010, d);
					chk(r, 0);
					chk(e, 1);
				end
				default: begin
					apb(1'b1, d[18] ? SPG_OFF_PIN_FUNCTION : SPG_OFF_PIN_DIRECTION, d);
					if (d[18]) m_fn = d[11:0];
					else m_dir = d[11:0];
					@(posedge i_sys_clk);
					i_latch_clear <= sd[11:0] & VM;
					@(posedge i_sys_clk);
					i_latch_clear <= '0;
					m_lat &= ~(sd[11:0] & VM & m_fn & m_dir);
					#1;
				end
			endcase
			mchk();
		end
		report_and_stop();
	end
endmodule
